// >>> hdl/xpdr_params.svh
`ifndef XPDR_PARAMS_SVH
`define XPDR_PARAMS_SVH
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define TE_SLOW_NS 200000
`define TE_FAST_NS 100000
`define TE_SLOW_CYC (`TE_SLOW_NS / `CLK_PERIOD_NS)
`define TE_FAST_CYC (`TE_FAST_NS / `CLK_PERIOD_NS)
`define EE_WR_MAX_MS 30
`define EE_WR_MAX_CYC (`EE_WR_MAX_MS * 1000000 / `CLK_PERIOD_NS)
// ----------------------------------------------------------------------
// opcodes and configuration fields
// ----------------------------------------------------------------------
`define OP_SELECT 5'h00
`define OP_PROGRAM 5'h08
`define CFG_TUNE_LSB 0
`define CFG_TUNE_MASK 16'h000f
`define CFG_RATE_BIT 4
`define CFG_COLLISION_AVOID_ENABLE_BIT 5
`define CFG_DUAL_BIT 6
// ----------------------------------------------------------------------
// storage word addresses
// ----------------------------------------------------------------------
`define EE_ADDR_SER_LO 5'h08
`define EE_ADDR_SER_HI 5'h09
`define EE_ADDR_USER0 5'h0a
`define EE_ADDR_CFG 5'h11
`define EE_LAST_WORD 5'h11
`endif

// >>> hdl/xpdr_pkg.sv
package xpdr_pkg;
  // one-hot command states
  typedef enum logic [12:0] {
    S_IDLE = 13'h0001, S_OPC = 13'h0002, S_TCODE = 13'h0004, S_DATA = 13'h0008,
    S_SEL = 13'h0010, S_CIPH = 13'h0020, S_PUSHLO = 13'h0040, S_EEWR = 13'h0080,
    S_ACK = 13'h0100, S_EERD = 13'h0200, S_ERASE = 13'h0400, S_PRGRD = 13'h0800,
    S_DRAIN = 13'h1000
  } state_t;
  typedef struct packed {
    logic req;
    logic we;
    logic erase;
    logic [4:0] addr;
    logic [15:0] wdata;
  } ee_req_t;
  typedef struct packed {
    logic start;
    logic key2;
    logic hop;
    logic [31:0] challenge;
  } ciph_req_t;
  typedef struct packed {
    logic first;
    logic [15:0] data;
  } resp_word_t;
  typedef struct packed {
    state_t state;
    logic sync1, sync2, prev, fsync1, fsync2, fprev;
    logic armed, cfg_loaded, train, muted, selected, pend;
    logic [15:0] rx_cnt;
    logic [31:0] rx_sh;
    logic [5:0] rx_n;
    logic [4:0] opc;
    logic [4:0] widx;
    logic [15:0] cfg;
    logic [15:0] ph_cnt;
    logic [1:0] ack_n;
    logic [17:0] tx_sh;
    logic [4:0] tx_n;
    logic tx_busy, tx_ph, drv;
    logic [15:0] tx_cnt;
    logic [19:0] wr_cnt;
    ee_req_t ee;
    ciph_req_t ciph;
  } ctl_t;
  localparam ctl_t CTL_RESET = '{state: S_IDLE, default: '0};
endpackage : xpdr_pkg

// >>> hdl/transponder_command_handler.sv
`timescale 1ns/100ps
`default_nettype none
`include "xpdr_params.svh"

// ----------------------------------------------------------------------
// response word buffer
// ----------------------------------------------------------------------
module resp_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fptr_t;
  fptr_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic wr_en, rd_en;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  assign o_in_ready = q.cnt < (AW + 1)'(DEPTH);
  assign o_out_valid = q.cnt != '0;
  assign o_out_data = mem[q.rd];
  assign wr_en = i_in_valid & o_in_ready;
  assign rd_en = i_out_ready & o_out_valid;

  // pointer update; full and empty come straight from the count
  always_comb begin
    d = q;
    if (wr_en) d.wr = q.wr + 1'b1;
    if (rd_en) d.rd = q.rd + 1'b1;
    d.cnt = q.cnt + (AW + 1)'(wr_en) - (AW + 1)'(rd_en);
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) q <= '0;
    else q <= d;
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge i_clk_sys) begin
    if (wr_en) mem[q.wr] <= i_in_data;
  end
endmodule : resp_fifo

// ----------------------------------------------------------------------
// coil link command interpreter
// ----------------------------------------------------------------------
module transponder_command_handler import xpdr_pkg::*; #(
  parameter int unsigned WR_TIMEOUT_CYC = `EE_WR_MAX_CYC,
  parameter int unsigned TE_FAST = `TE_FAST_CYC,
  parameter int unsigned TE_SLOW = `TE_SLOW_CYC,
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_coil_pin_a,
  output logic o_coil_pin_a,
  output logic o_coil_pin_a_oe,
  input wire logic i_field_present,
  output ee_req_t o_ee,
  input wire logic i_ee_done,
  input wire logic [15:0] i_ee_rdata,
  input wire logic [15:0] i_cfg_word,
  input wire logic [31:0] i_serial_number,
  input wire logic [31:0] i_transport_code,
  output ciph_req_t o_ciph,
  input wire logic i_ciph_done,
  input wire logic [31:0] i_ciph_resp,
  output logic [3:0] o_osc_tune
);
  ctl_t q, d;
  logic [15:0] te;
  logic rise, bit_val, gap, tx_pop, dual_key_auth_mode, gate, ph_end;
  logic push, f_in_ready, f_out_valid;
  resp_word_t push_word, f_out;
  logic [5:0] need;

  if (WR_TIMEOUT_CYC < 1 || WR_TIMEOUT_CYC >= (1 << 20)) begin : g_bad_timeout
    $error("write timeout must fit 20 bits");
  end
  // eight slow elements must fit the 16-bit edge spacing counter
  if (TE_FAST < 2 || TE_SLOW < 2 || 8 * TE_SLOW >= (1 << 16)) begin : g_bad_te
    $error("element length must fit the edge counter");
  end

  // scaled element length; operands stay 16 bits wide
  function automatic logic [15:0] te_x(input logic [15:0] t, input logic [3:0] k);
    return 16'(t * k);
  endfunction : te_x

  // word address of the register an opcode reads or writes
  function automatic logic [4:0] addr_of(input logic [4:0] o);
    if (o[2]) return `EE_ADDR_USER0 + {3'h0, o[1:0]};
    unique case (o[1:0])
      2'h2: return `EE_ADDR_SER_LO;
      2'h3: return `EE_ADDR_SER_HI;
      default: return `EE_ADDR_CFG;
    endcase
  endfunction : addr_of

  // compare the first n received bits with the top n serial bits
  function automatic logic sel_match(input logic [31:0] sh, input logic [5:0] n,
                                     input logic [31:0] ser);
    logic [31:0] m;
    m = (n >= 6'd32) ? 32'hffffffff : ((32'h1 << n) - 32'h1);
    return (n != 6'd0) && ((sh & m) == ((ser >> (6'd32 - n)) & m));
  endfunction : sel_match

  // live configuration only changes at reset or after erase
  assign te = q.cfg[`CFG_RATE_BIT] ? 16'(TE_FAST) : 16'(TE_SLOW);
  assign dual_key_auth_mode = q.cfg[`CFG_DUAL_BIT];
  assign gate = q.muted | (q.cfg[`CFG_COLLISION_AVOID_ENABLE_BIT] & ~q.selected);
  // own pulses are masked so the line only reports the decoder's edges
  assign rise = q.sync2 & ~q.prev & ~q.drv;
  assign bit_val = q.rx_cnt < te_x(te, 4'd5);
  assign gap = q.armed & (q.rx_cnt == te_x(te, 4'd8));
  assign ph_end = q.ph_cnt == te - 16'h1;
  assign tx_pop = ~q.tx_busy & f_out_valid;

  resp_fifo #(.WIDTH($bits(resp_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_in_valid(push),
    .o_in_ready(f_in_ready),
    .i_in_data(push_word),
    .o_out_valid(f_out_valid),
    .i_out_ready(tx_pop),
    .o_out_data(f_out)
  );

  // next-state logic for the whole interpreter
  always_comb begin
    d = q;
    push = 1'b0;
    push_word = '0;
    need = 6'd32;
    d.sync1 = i_coil_pin_a;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    d.fsync1 = i_field_present;
    d.fsync2 = q.fsync1;
    d.fprev = q.fsync2;
    d.ee.req = 1'b0;
    d.ciph.start = 1'b0;
    // configuration captured once after reset; later writes wait for reset
    if (!q.cfg_loaded) begin
      d.cfg = i_cfg_word;
      d.cfg_loaded = 1'b1;
    end
    // element phase counter shared by acknowledge train and pulse pairs
    d.ph_cnt = ph_end ? 16'h0 : q.ph_cnt + 16'h1;
    if (ph_end) d.ack_n = q.ack_n + 2'h1;
    // field entry starts the acknowledge train unless muted, leaving clears selection
    if (q.fsync2 & ~q.fprev) begin
      d.train = ~q.muted;
      d.ph_cnt = 16'h0;
      d.ack_n = 2'h0;
    end
    if (~q.fsync2 & q.fprev) begin
      d.train = 1'b0;
      d.muted = 1'b0;
      d.selected = 1'b0;
    end
    // edge spacing counter saturates so an idle line stays quiet
    d.rx_cnt = rise ? 16'h0 : ((&q.rx_cnt) ? q.rx_cnt : q.rx_cnt + 16'h1);
    if (rise & q.armed) begin
      d.rx_sh = {q.rx_sh[30:0], bit_val};
      d.rx_n = q.rx_n + 6'd1;
    end
    // response transmitter: high one element, low one or two
    if (tx_pop) begin
      d.tx_busy = 1'b1;
      d.tx_ph = 1'b0;
      d.tx_cnt = 16'h0;
      d.tx_sh = f_out.first ? {2'b01, f_out.data} : {f_out.data, 2'b00};
      d.tx_n = f_out.first ? 5'd18 : 5'd16;
    end else if (q.tx_busy) begin
      d.tx_cnt = q.tx_cnt + 16'h1;
      if (!q.tx_ph) begin
        if (q.tx_cnt == te - 16'h1) begin
          d.tx_cnt = 16'h0;
          if (q.tx_n == 5'd0) d.tx_busy = 1'b0;
          else d.tx_ph = 1'b1;
        end
      end else if (q.tx_cnt == (q.tx_sh[17] ? te : te_x(te, 4'd2)) - 16'h1) begin
        d.tx_cnt = 16'h0;
        d.tx_ph = 1'b0;
        d.tx_sh = {q.tx_sh[16:0], 1'b0};
        d.tx_n = q.tx_n - 5'd1;
      end
    end
    // command sequencing
    unique case (q.state)
      S_IDLE: begin
        if (rise & ~q.tx_busy) begin
          d.train = 1'b0;
          d.armed = 1'b1;
          d.rx_n = 6'd0;
          d.rx_sh = 32'h0;
          d.state = S_OPC;
        end
      end
      S_SEL: begin
        if (rise & ~q.armed) begin
          d.armed = 1'b1;
          d.rx_sh = 32'h0;
        end
        if (gap || d.rx_n == 6'd32) begin
          d.armed = 1'b0;
          d.rx_n = 6'd0;
          if (sel_match(d.rx_sh, gap ? q.rx_n : 6'd32, i_serial_number)) begin
            d.selected = 1'b1;
            d.muted = 1'b0;
            d.ack_n = 2'h0;
            d.ph_cnt = 16'h0;
            d.state = S_ACK;
          end else begin
            d.muted = 1'b1;
            d.state = S_IDLE;
          end
        end
      end
      S_OPC, S_TCODE, S_DATA: begin
        if (q.state == S_OPC) need = 6'd5;
        else if (q.state == S_DATA && !q.opc[4]) need = 6'd16;
        if (rise & ~q.armed) begin
          d.armed = 1'b1;
          d.rx_sh = 32'h0;
        end
        if (gap) begin
          d.armed = 1'b0;
          d.rx_n = 6'd0;
          d.state = S_IDLE;
        end else if (d.rx_n == need) begin
          d.armed = 1'b0;
          d.rx_n = 6'd0;
          if (q.state == S_OPC) begin
            d.opc = d.rx_sh[4:0];
            d.widx = 5'd0;
            if (gate && d.opc != `OP_SELECT) d.state = S_IDLE;
            else if (d.opc == `OP_SELECT) d.state = S_SEL;
            else if (d.opc[4]) begin
              if (!d.opc[1] && (!d.opc[2] || dual_key_auth_mode)) d.state = S_DATA;
              else d.state = S_IDLE;
            end else if (!d.opc[3]) begin
              d.ee = '{req: 1'b1, we: 1'b0, erase: 1'b0, addr: addr_of(d.opc), wdata: 16'h0};
              d.state = S_EERD;
            end else if (!d.opc[2]) d.state = S_TCODE;
            else d.state = S_DATA;
          end else if (q.state == S_TCODE) begin
            if (d.rx_sh != i_transport_code) d.state = S_IDLE;
            else if (q.opc == `OP_PROGRAM) begin
              d.ee = '{req: 1'b1, we: 1'b1, erase: 1'b1, addr: 5'h0, wdata: 16'h0};
              d.wr_cnt = 20'h0;
              d.state = S_ERASE;
            end else d.state = S_DATA;
          end else if (q.opc[4]) begin
            d.ciph = '{start: 1'b1, key2: q.opc[2], hop: q.opc[0], challenge: d.rx_sh};
            d.state = S_CIPH;
          end else begin
            d.ee.req = 1'b1;
            d.ee.we = 1'b1;
            d.ee.erase = 1'b0;
            d.ee.addr = (q.opc == `OP_PROGRAM) ? q.widx : addr_of(q.opc);
            d.ee.wdata = d.rx_sh[15:0];
            d.wr_cnt = 20'h0;
            d.state = S_EEWR;
          end
        end
      end
      S_EEWR, S_ERASE: begin
        d.wr_cnt = q.wr_cnt + 20'h1;
        if (i_ee_done) begin
          if (q.state == S_ERASE) begin
            d.cfg = i_cfg_word & ~`CFG_TUNE_MASK;
            d.state = S_DATA;
          end else begin
            d.ack_n = 2'h0;
            d.ph_cnt = 16'h0;
            d.state = S_ACK;
          end
        end else if (q.wr_cnt == 20'(WR_TIMEOUT_CYC - 1)) d.state = S_IDLE;
      end
      S_ACK: begin
        if (ph_end && q.ack_n == 2'h3) begin
          if (q.opc != `OP_PROGRAM) d.state = S_IDLE;
          else if (q.widx == `EE_LAST_WORD) begin
            d.widx = 5'd0;
            d.pend = 1'b0;
            d.state = S_PRGRD;
          end else begin
            d.widx = q.widx + 5'd1;
            d.state = S_DATA;
          end
        end
      end
      S_EERD: begin
        if (i_ee_done) begin
          push = 1'b1;
          push_word = '{first: 1'b1, data: i_ee_rdata};
          d.state = S_DRAIN;
        end
      end
      S_CIPH: begin
        if (i_ciph_done) begin
          push = 1'b1;
          push_word = '{first: 1'b1, data: i_ciph_resp[31:16]};
          d.rx_sh = i_ciph_resp;
          d.state = S_PUSHLO;
        end
      end
      S_PUSHLO: begin
        if (f_in_ready) begin
          push = 1'b1;
          push_word = '{first: 1'b0, data: q.rx_sh[15:0]};
          d.state = S_DRAIN;
        end
      end
      S_PRGRD: begin
        // a read is issued only with room free, so its word always fits
        if (q.pend) begin
          if (i_ee_done) begin
            push = 1'b1;
            push_word = '{first: 1'b1, data: i_ee_rdata};
            d.pend = 1'b0;
            d.widx = q.widx + 5'd1;
            if (q.widx == `EE_LAST_WORD) d.state = S_DRAIN;
          end
        end else if (f_in_ready) begin
          d.ee = '{req: 1'b1, we: 1'b0, erase: 1'b0, addr: q.widx, wdata: 16'h0};
          d.pend = 1'b1;
        end
      end
      S_DRAIN: begin
        if (!f_out_valid && !q.tx_busy) d.state = S_IDLE;
      end
      default: d.state = S_IDLE;
    endcase
    d.drv = (d.tx_busy & ~d.tx_ph) | (d.state == S_ACK & ~d.ack_n[0])
          | (d.state == S_IDLE & d.train & ~d.ack_n[0]);
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) q <= CTL_RESET;
    else q <= d;
  end

  assign o_coil_pin_a = q.drv;
  assign o_coil_pin_a_oe = q.drv;
  assign o_ee = q.ee;
  assign o_ciph = q.ciph;
  assign o_osc_tune = q.cfg[`CFG_TUNE_LSB +: 4];

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic drv_prev_q;
  logic [2:0] ack_rises_q;
  logic tc_seen_q;
  // helper: count pulse starts inside an acknowledge pair
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      drv_prev_q <= 1'b0;
      ack_rises_q <= 3'h0;
      tc_seen_q <= 1'b0;
    end else begin
      drv_prev_q <= q.drv;
      if (q.state != S_ACK) ack_rises_q <= 3'h0;
      else if (q.drv && !drv_prev_q) ack_rises_q <= ack_rises_q + 3'h1;
      if (q.state == S_IDLE) tc_seen_q <= 1'b0;
      else if (q.state == S_TCODE && d.state != S_TCODE && d.state != S_IDLE)
        tc_seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  AST_PREAMBLE: assert property (tx_pop && f_out.first |=> q.tx_sh[17:16] == 2'b01
    && q.tx_n == 5'd18) else $error("response lacks preamble");
  AST_ACK_PAIR: assert property ($fell(q.state == S_ACK) |-> $past(ack_rises_q) == 3'h2)
    else $error("acknowledge is not two pulses");
  AST_MAPPED_ONLY: assert property (q.ee.req && !q.ee.erase && q.opc != `OP_PROGRAM
    |-> q.ee.addr == `EE_ADDR_CFG || (q.ee.addr >= `EE_ADDR_SER_LO
    && q.ee.addr <= `EE_ADDR_USER0 + 5'h3)) else $error("access outside user map");
  AST_TCODE_FIRST: assert property (q.ee.req && q.ee.we && !q.opc[2]
    |-> tc_seen_q) else $error("protected write without transport code");
  AST_CFG_HOLD: assert property ($past(q.cfg_loaded) && !$past(q.state == S_ERASE)
    |-> $stable(q.cfg)) else $error("configuration changed without reset");
  AST_READ_DRAIN: assert property (q.state == S_EERD && i_ee_done
    |=> q.state == S_DRAIN ##1 f_out_valid || q.tx_busy) else $error("read gave no response");
  AST_KEY_PICK: assert property (q.ciph.start |-> q.ciph.key2 == q.opc[2]
    && q.ciph.hop == q.opc[0] && q.opc[4] && !q.opc[1]) else $error("wrong key or algorithm");
  AST_ERASE_TUNE: assert property (q.state == S_ERASE && i_ee_done
    |=> o_osc_tune == 4'h0 && q.state == S_DATA) else $error("tuning not cleared after erase");
  AST_SEL_ACK: assert property ($rose(q.selected) |-> q.state == S_ACK
    && $past(q.state) == S_SEL) else $error("select acknowledge missing");
  AST_TRAIN_STOP: assert property (q.state == S_IDLE && q.train && rise
    |=> !q.train && q.state == S_OPC) else $error("train not stopped by start bit");
  AST_WR_BOUND: assert property (q.state == S_EEWR |-> q.wr_cnt < 20'(WR_TIMEOUT_CYC))
    else $error("write wait beyond limit");
  AST_BACK_TO_IDLE: assert property (q.state == S_DRAIN && !f_out_valid && !q.tx_busy
    |=> q.state == S_IDLE) else $error("device did not return to idle");

  COV_READ: cover property (q.state == S_EERD ##1 q.state == S_DRAIN);
  COV_PROGRAM: cover property (q.state == S_ERASE && i_ee_done);
  COV_SELECT: cover property ($rose(q.selected));
  COV_CIPHER: cover property (q.state == S_PUSHLO ##1 q.state == S_DRAIN);
endmodule : transponder_command_handler
`default_nettype wire

// >>> verification/coil_decoder_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// base station side of the coil link
// ----------------------------------------------------------------------
module coil_decoder_model #(
  parameter int TE = 2000
) (
  input wire logic i_clk_sys,
  input wire logic i_line,
  output logic o_drive
);
  initial o_drive = 1'b0;

  // one rising edge, held 2 elements so the minimum high time has margin
  task automatic pulse();
    @(posedge i_clk_sys) #1 o_drive = 1'b1;
    repeat (2 * TE) @(posedge i_clk_sys);
    #1 o_drive = 1'b0;
  endtask : pulse

  // start rise, then bits msb first as rise-to-rise spacing
  task automatic send(input logic [31:0] v, input int n, input bit start);
    if (start) pulse();
    for (int i = n - 1; i >= 0; i--) begin
      repeat ((v[i] ? 2 : 4) * TE - 1) @(posedge i_clk_sys);
      pulse();
    end
  endtask : send

  // device burst: 2 elements between rises is a 1, 3 is a 0
  // sampled on the falling edge so registered outputs have settled
  task automatic recv(output logic [17:0] w);
    int t;
    w = '0;
    for (t = 0; t < 240 * TE && !i_line; t++) @(negedge i_clk_sys);
    for (int b = 0; b < 18; b++) begin
      t = 0;
      do begin @(negedge i_clk_sys); t++; end while (i_line && t < 4 * TE);
      while (!i_line && t < 4 * TE) begin @(negedge i_clk_sys); t++; end
      w = {w[16:0], t < 5 * TE / 2};
    end
    // let the closing marker end, or a following start rise is hidden under it
    while (i_line) @(negedge i_clk_sys);
  endtask : recv

  // counts rises and high cycles in a window starting at the first device pulse
  task automatic acks(output int n, output int hi);
    logic prev;
    n = 0;
    hi = 0;
    prev = 1'b0;
    for (int t = 0; t < 240 * TE && !i_line; t++) @(negedge i_clk_sys);
    for (int t = 0; t < 6 * TE; t++) begin
      n += int'(i_line && !prev);
      hi += int'(i_line);
      prev = i_line;
      @(negedge i_clk_sys);
    end
  endtask : acks
endmodule : coil_decoder_model
`default_nettype wire

// >>> verification/tb_transponder_command_handler.sv
`timescale 1ns/100ps
`default_nettype none
module tb_transponder_command_handler import xpdr_pkg::*;;
  // rate bit set: element shortened to 20 cycles to keep the run short; tuning field 3
  localparam int TE = 20;
  localparam logic [15:0] CFG = 16'h0013, RDATA = 16'h5a3c;
  localparam logic [31:0] TCODE = 32'h6b1e40c7, CRESP = 32'h0f1e2d3c, CHAL = 32'h84217bde;
  logic clk, rstn, drv, ee_done, ciph_done, o_coil, oe;
  logic [15:0] ee_rdata;
  logic [3:0] tune;
  ee_req_t ee, ee_seen;
  ciph_req_t ciph, ciph_seen;
  int n_errors = 0, checked = 0, n_req = 0;
  // wired line: the device never sees its own pulses as decoder edges
  wire logic line = drv | (oe & o_coil);
  wire logic dev_line = oe & o_coil;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  transponder_command_handler #(.WR_TIMEOUT_CYC(200), .TE_FAST(TE), .TE_SLOW(2 * TE),
    .FIFO_DEPTH(4)) DUT (
    .i_clk_sys(clk), .i_rstn(rstn), .i_coil_pin_a(line), .o_coil_pin_a(o_coil),
    .o_coil_pin_a_oe(oe), .i_field_present(1'b0), .o_ee(ee), .i_ee_done(ee_done),
    .i_ee_rdata(ee_rdata), .i_cfg_word(CFG), .i_serial_number(32'h1234abcd),
    .i_transport_code(TCODE), .o_ciph(ciph), .i_ciph_done(ciph_done),
    .i_ciph_resp(CRESP), .o_osc_tune(tune));

  coil_decoder_model #(.TE(TE)) DEC (.i_clk_sys(clk), .i_line(dev_line), .o_drive(drv));

  // storage and cipher answer one cycle after each request
  always @(posedge clk) begin
    ee_done <= #1 ee.req;
    ee_rdata <= #1 ee.req ? RDATA : 16'h0000;
    ciph_done <= #1 ciph.start;
    if (ee.req) begin
      ee_seen <= ee;
      n_req <= n_req + 1;
    end
    if (ciph.start) ciph_seen <= ciph;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // every read opcode in turn, each answered once before the next
  task automatic t_reads();
    logic [17:0] w;
    for (int op = 1; op < 8; op++) begin
      fork DEC.send(op, 5, 1); DEC.recv(w); join
      chk(ee_seen.addr, op == 1 ? 5'h11 : 5'(op + 6));
      chk(ee_seen.we, 1'b0);
      chk(w, {2'b01, RDATA});
    end
  endtask : t_reads

  task automatic t_write_user();
    int n, hi;
    DEC.send(5'h0d, 5, 1);
    fork DEC.send(16'h9bd2, 16, 1); DEC.acks(n, hi); join
    chk(n, 2);
    chk(hi, 2 * TE);
    chk(ee_seen, {3'b110, 5'h0b, 16'h9bd2});
  endtask : t_write_user

  // a wrong code must be dropped silently, the right one lets data through
  task automatic t_write_cfg();
    int n, hi, base;
    base = n_req;
    DEC.send(5'h09, 5, 1);
    fork DEC.send(~TCODE, 32, 1); DEC.acks(n, hi); join
    chk(n, 0);
    chk(n_req, base);
    DEC.send(5'h09, 5, 1);
    DEC.send(TCODE, 32, 1);
    fork DEC.send(16'h0007, 16, 1); DEC.acks(n, hi); join
    chk(n, 2);
    chk(ee_seen, {3'b110, 5'h11, 16'h0007});
    chk(tune, 4'h3);
  endtask : t_write_cfg

  task automatic t_unknown();
    int n, hi, base;
    base = n_req;
    fork DEC.send(5'h1a, 5, 1); DEC.acks(n, hi); join
    chk(n, 0);
    chk(n_req, base);
  endtask : t_unknown

  // first key, hopping algorithm; high word with preamble, low word without
  task automatic t_cipher();
    logic [17:0] w;
    DEC.send(5'h19, 5, 1);
    fork DEC.send(CHAL, 32, 1); DEC.recv(w); join
    chk(ciph_seen, {3'b101, CHAL});
    chk(w, {2'b01, CRESP[31:16]});
    DEC.recv(w);
    chk(w, {CRESP[15:0], 2'b00});
  endtask : t_cipher

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  initial begin
    rstn = 1'b0;
    ee_done = 1'b0;
    ee_rdata = 16'h0000;
    ciph_done = 1'b0;
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    chk(tune, 4'h3);
    t_reads();
    t_write_user();
    t_write_cfg();
    t_unknown();
    t_cipher();
    complete_run();
  end

  // the whole sequence needs about 2 ms of link time
  initial begin
    #5000000;
    n_errors++;
    complete_run();
  end
endmodule : tb_transponder_command_handler
`default_nettype wire
